// >>> rtl/tws_pkg.sv
package tws_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Slave address selection
    ////////////////////////////////////////////////////////////////////////////
    localparam logic [6:0]  TWS_DEF_SLV_ADDR  = 7'h10;    // Address byte 0x20 write, 0x21 read
    localparam logic [6:0]  TWS_ALT_SLV_ADDR  = 7'h18;    // Address byte 0x30 write, 0x31 read

    ////////////////////////////////////////////////////////////////////////////
    // Register map, 16-bit byte addresses, eight-bit bytes
    ////////////////////////////////////////////////////////////////////////////
    localparam logic [15:0] TWS_OVR_HI_ADDR   = 16'h31fc; // slave_address_override, high byte
    localparam logic [15:0] TWS_OVR_LO_ADDR   = 16'h31fd; // slave_address_override, low byte
    localparam logic [15:0] TWS_STAT_HI_ADDR  = 16'h31fe; // Link status, high byte, reads zero
    localparam logic [15:0] TWS_STAT_LO_ADDR  = 16'h31ff; // Link status, low byte
    localparam logic [15:0] TWS_OVR_RESET     = 16'h0000; // Override off, pin select off
    localparam logic [7:0]  TWS_ZERO_BYTE     = 8'h00;    // Reserved read value

    // Field layout of slave_address_override
    localparam int          TWS_OVR_ADDR_MSB  = 7;        // Programmed address, top bit
    localparam int          TWS_OVR_ADDR_LSB  = 1;        // Programmed address, bottom bit
    localparam int          TWS_OVR_EN_BIT    = 8;        // Use programmed address
    localparam int          TWS_OVR_PIN_BIT   = 9;        // Let the address-select pin act

    ////////////////////////////////////////////////////////////////////////////
    // Serial framing
    ////////////////////////////////////////////////////////////////////////////
    localparam logic [3:0]  TWS_LAST_BIT      = 4'h7;     // Index of the eighth data bit
    localparam logic [3:0]  TWS_ACK_SLOT      = 4'h8;     // Ninth period carries the acknowledge
    localparam logic [3:0]  TWS_FIRST_AFTER   = 4'h1;     // Count after the bit taken with a start

    // Link states, Gray along idle, address, register high, register low, write data
    typedef enum logic [2:0] {
        TWS_IDLE   = 3'h0,
        TWS_ADDR   = 3'h1,
        TWS_REG_HI = 3'h3,
        TWS_REG_LO = 3'h2,
        TWS_WDATA  = 3'h6,
        TWS_RDATA  = 3'h7
    } tws_state_e;

endpackage

// >>> rtl/tws_sync.sv
`timescale 1ns/1ns
module tws_sync #(
    parameter int WIDTH = 1                 // Number of independent bits
) (
    input  wire logic             clk,      // Destination clock
    input  wire logic             en,       // Freeze while low
    input  wire logic [WIDTH-1:0] d,        // Asynchronous input
    output      logic [WIDTH-1:0] q         // Synchronised output
);

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage synchroniser; first stage feeds only the second
    ////////////////////////////////////////////////////////////////////////////
    logic [WIDTH-1:0] meta_q;               // First stage, may go metastable
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;               // Second stage, safe to use
    logic [WIDTH-1:0] sync_d;

    // Next values, held while frozen
    always_comb begin
        meta_d = en ? d : meta_q;
        sync_d = en ? meta_q : sync_q;
    end

    // Stages
    always_ff @(posedge clk) begin
        meta_q <= meta_d;
        sync_q <= sync_d;
    end

    assign q = sync_q;

endmodule

// >>> rtl/tws_slave.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Slave only; never starts a transfer
// - Serial clock is input only, no stretching
// - Pull data low only in our phase
// - Both lines high means bus idle
// - Start: data falls while clock high
// - Repeated start begins a new transfer
// - Stop: data rises while clock high
// - Bytes are eight bits, MSB first
// - Each byte followed by an acknowledge slot
// - One bit per clock; data stable high
// - Address byte: seven-bit address, bit zero direction
// - Default addresses 0x20 write, 0x21 read
// - Enabled select pin gives 0x30 and 0x31
// - Register can replace the slave address
// - Message bytes: register address, write, read data
// - Reset restores every register default
// - Transmitter releases data during acknowledge slot
// - Write: two address bytes high first, acknowledged
// - Pointer advances by one per byte
module tws_slave #(
    parameter int ADDR_W = 16,              // Register address width
    parameter int DATA_W = 8                // Register data width
) (
    input  wire logic              clk,         // System clock
    input  wire logic              rst_n,       // Reset, active low
    input  wire logic              ce,          // Clock enable for system-side state
    input  wire logic              sclk,        // Serial clock from the master
    input  wire logic              sda_i,       // Serial data line level
    output      logic              sda_o,       // Serial data drive value
    output      logic              sda_oe,      // Serial data pull-down enable
    input  wire logic              saddr,       // Address-select pin
    output      logic              reg_wr_stb,  // Write to a sensor register
    output      logic              reg_rd_stb,  // Read of a sensor register
    output      logic [ADDR_W-1:0] reg_addr,    // Register address
    output      logic [DATA_W-1:0] reg_wdata,   // Register write data
    input  wire logic [DATA_W-1:0] reg_rdata    // Register read data, same cycle
);

    ////////////////////////////////////////////////////////////////////////////
    // Start and stop catchers, clocked by the data line itself
    ////////////////////////////////////////////////////////////////////////////
    logic start_q;                          // Start seen, awaiting the link logic
    logic stop_q;                           // Stop seen, awaiting the link logic
    logic evt_clr_q;                        // Link logic consumed the events
    logic evt_clr;                          // Clear for both catchers

    // Reset clears them as well, since the serial clock may be still
    assign evt_clr = evt_clr_q | ~rst_n;

    // Falling data while clock high is a start; sticky until consumed
    always_ff @(negedge sda_i or posedge evt_clr) begin
        if (evt_clr) begin
            start_q <= 1'h0;
        end else begin
            start_q <= start_q | sclk;
        end
    end

    // Rising data while clock high is a stop
    always_ff @(posedge sda_i or posedge evt_clr) begin
        if (evt_clr) begin
            stop_q <= 1'h0;
        end else begin
            stop_q <= stop_q | sclk;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link-side byte engine on the serial clock
    ////////////////////////////////////////////////////////////////////////////
    tws_pkg::tws_state_e state_q;           // Transfer phase
    tws_pkg::tws_state_e state_d;
    logic [3:0]          bit_cnt_q;         // Bits of the byte done, eight is the ack slot
    logic [3:0]          bit_cnt_d;
    logic [7:0]          rx_q;              // Receive shifter
    logic [7:0]          rx_d;
    logic [7:0]          tx_q;              // Transmit shifter, MSB is on the line
    logic [7:0]          tx_d;
    logic                rw_q;              // Direction of this transfer
    logic                rw_d;
    logic                ack_q;             // We acknowledge in the coming slot
    logic                ack_d;
    logic [ADDR_W-1:0]   ptr_q;             // Register address pointer
    logic [ADDR_W-1:0]   ptr_d;
    logic [ADDR_W-1:0]   wr_addr_q;         // Held write address for the system side
    logic [ADDR_W-1:0]   wr_addr_d;
    logic [DATA_W-1:0]   wr_data_q;         // Held write data for the system side
    logic [DATA_W-1:0]   wr_data_d;
    logic                wr_tgl_q;          // Flips once per write
    logic                wr_tgl_d;
    logic                fetch_tgl_q;       // Flips once per new pointer to prefetch
    logic                fetch_tgl_d;
    logic                evt_clr_d;
    logic [7:0]          byte_v;            // Byte completed by the present bit
    logic [6:0]          my_addr_s;         // Selected slave address, link side
    logic [DATA_W-1:0]   rd_data_q;         // Prefetched read byte, system side

    // Next-state logic; sda_i sampled at the rising clock edge
    always_comb begin
        state_d     = state_q;
        bit_cnt_d   = bit_cnt_q;
        rx_d        = rx_q;
        tx_d        = tx_q;
        rw_d        = rw_q;
        ack_d       = ack_q;
        ptr_d       = ptr_q;
        wr_addr_d   = wr_addr_q;
        wr_data_d   = wr_data_q;
        wr_tgl_d    = wr_tgl_q;
        fetch_tgl_d = fetch_tgl_q;
        evt_clr_d   = start_q | stop_q;
        byte_v      = {rx_q[6:0], sda_i};
        if (start_q) begin
            // New or repeated start; this edge carries the first address bit
            state_d   = tws_pkg::TWS_ADDR;
            bit_cnt_d = tws_pkg::TWS_FIRST_AFTER;
            rx_d      = {7'h00, sda_i};
            ack_d     = 1'h0;
        end else if (stop_q) begin
            // Bus given back; wait quietly for the next start
            state_d   = tws_pkg::TWS_IDLE;
            bit_cnt_d = 4'h0;
            ack_d     = 1'h0;
        end else if (state_q != tws_pkg::TWS_IDLE) begin
            if (bit_cnt_q != tws_pkg::TWS_ACK_SLOT) begin
                // One bit per clock period
                rx_d      = byte_v;
                tx_d      = {tx_q[6:0], 1'h1};
                bit_cnt_d = bit_cnt_q + 4'h1;
                if (bit_cnt_q == tws_pkg::TWS_LAST_BIT) begin
                    ack_d = 1'h1;
                    unique case (state_q)
                        tws_pkg::TWS_ADDR: begin
                            rw_d = byte_v[0];
                            if (byte_v[7:1] != my_addr_s) begin
                                ack_d   = 1'h0;
                                state_d = tws_pkg::TWS_IDLE;
                            end
                        end
                        tws_pkg::TWS_REG_HI: begin
                            ptr_d[15:8] = byte_v;
                        end
                        tws_pkg::TWS_REG_LO: begin
                            ptr_d[7:0]  = byte_v;
                            fetch_tgl_d = ~fetch_tgl_q;
                        end
                        tws_pkg::TWS_WDATA: begin
                            wr_addr_d   = ptr_q;
                            wr_data_d   = byte_v;
                            wr_tgl_d    = ~wr_tgl_q;
                            ptr_d       = ptr_q + 16'h0001;
                            fetch_tgl_d = ~fetch_tgl_q;
                        end
                        tws_pkg::TWS_RDATA: begin
                            ack_d = 1'h0;   // Master acknowledges our data
                        end
                        tws_pkg::TWS_IDLE: begin
                            ack_d = 1'h0;
                        end
                    endcase
                end
            end else begin
                // Acknowledge slot just sampled
                bit_cnt_d = 4'h0;
                ack_d     = 1'h0;
                unique case (state_q)
                    tws_pkg::TWS_ADDR: begin
                        if (rw_q) begin
                            state_d     = tws_pkg::TWS_RDATA;
                            tx_d        = rd_data_q;
                            ptr_d       = ptr_q + 16'h0001;
                            fetch_tgl_d = ~fetch_tgl_q;
                        end else begin
                            state_d = tws_pkg::TWS_REG_HI;
                        end
                    end
                    tws_pkg::TWS_REG_HI: begin
                        state_d = tws_pkg::TWS_REG_LO;
                    end
                    tws_pkg::TWS_REG_LO: begin
                        state_d = tws_pkg::TWS_WDATA;
                    end
                    tws_pkg::TWS_WDATA: begin
                        state_d = tws_pkg::TWS_WDATA;           // Sequential writes
                    end
                    tws_pkg::TWS_RDATA: begin
                        if (sda_i) begin
                            state_d = tws_pkg::TWS_IDLE;
                        end else begin
                            tx_d        = rd_data_q;
                            ptr_d       = ptr_q + 16'h0001;
                            fetch_tgl_d = ~fetch_tgl_q;
                        end
                    end
                    tws_pkg::TWS_IDLE: begin
                        state_d = tws_pkg::TWS_IDLE;
                    end
                endcase
            end
        end
    end

    // Link registers; reset acts without the serial clock, which may be still
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= tws_pkg::TWS_IDLE;
            bit_cnt_q   <= 4'h0;
            rx_q        <= 8'h00;
            tx_q        <= 8'hff;
            rw_q        <= 1'h0;
            ack_q       <= 1'h0;
            ptr_q       <= 16'h0000;
            wr_addr_q   <= 16'h0000;
            wr_data_q   <= 8'h00;
            wr_tgl_q    <= 1'h0;
            fetch_tgl_q <= 1'h0;
            evt_clr_q   <= 1'h0;
        end else begin
            state_q     <= state_d;
            bit_cnt_q   <= bit_cnt_d;
            rx_q        <= rx_d;
            tx_q        <= tx_d;
            rw_q        <= rw_d;
            ack_q       <= ack_d;
            ptr_q       <= ptr_d;
            wr_addr_q   <= wr_addr_d;
            wr_data_q   <= wr_data_d;
            wr_tgl_q    <= wr_tgl_d;
            fetch_tgl_q <= fetch_tgl_d;
            evt_clr_q   <= evt_clr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data line driver, set on the falling serial clock, freed at once by a start or stop
    ////////////////////////////////////////////////////////////////////////////
    logic drive_q;                          // Pull the data line low
    logic drive_d;

    // Ack slot: our acknowledge; read bytes: zeros of the shifter
    always_comb begin
        if (bit_cnt_q == tws_pkg::TWS_ACK_SLOT) begin
            drive_d = ack_q;
        end else begin
            drive_d = (state_q == tws_pkg::TWS_RDATA) & ~tx_q[7];
        end
    end

    // Register the drive
    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            drive_q <= 1'h0;
        end else begin
            drive_q <= drive_d;
        end
    end

    // Open drain; a start or stop frees the line at once.
    // There is no clock output at all: the master owns the clock.
    assign sda_o  = 1'h0;
    assign sda_oe = drive_q & ~start_q & ~stop_q;

    ////////////////////////////////////////////////////////////////////////////
    // System side: register file and sensor register port
    ////////////////////////////////////////////////////////////////////////////
    logic [15:0]       ovr_q;               // slave_address_override
    logic [15:0]       ovr_d;
    logic [6:0]        my_addr_q;           // Selected slave address
    logic [6:0]        my_addr_d;
    logic              wr_seen_q;           // Last write toggle handled
    logic              wr_seen_d;
    logic              fetch_seen_q;        // Last fetch toggle handled
    logic              fetch_seen_d;
    logic              fetch_pend_q;        // Read address presented this cycle
    logic              fetch_pend_d;
    logic              wr_stb_q;
    logic              wr_stb_d;
    logic [ADDR_W-1:0] reg_addr_q;
    logic [ADDR_W-1:0] reg_addr_d;
    logic [DATA_W-1:0] reg_wdata_q;
    logic [DATA_W-1:0] reg_wdata_d;
    logic [DATA_W-1:0] rd_data_d;
    logic              saddr_s;             // Address-select pin, synchronised
    logic              wr_tgl_s;
    logic              fetch_tgl_s;

    // Pin and toggles into the system clock
    tws_sync #(
        .WIDTH (3)
    ) u_sync_sys (
        .clk (clk),
        .en  (ce),
        .d   ({saddr, wr_tgl_q, fetch_tgl_q}),
        .q   ({saddr_s, wr_tgl_s, fetch_tgl_s})
    );

    // Selected address into the serial clock; quasi-static, changes between transfers
    tws_sync #(
        .WIDTH (7)
    ) u_sync_link (
        .clk (sclk),
        .en  (1'h1),
        .d   (my_addr_q),
        .q   (my_addr_s)
    );

    // Write first; a fetch waits one cycle if both arrive together
    always_comb begin
        ovr_d        = ovr_q;
        wr_seen_d    = wr_tgl_s;
        fetch_seen_d = fetch_seen_q;
        fetch_pend_d = 1'h0;
        wr_stb_d     = 1'h0;
        reg_addr_d   = reg_addr_q;
        reg_wdata_d  = reg_wdata_q;
        rd_data_d    = rd_data_q;
        // Address choice: programmed, then pin, then default
        if (ovr_q[tws_pkg::TWS_OVR_EN_BIT]) begin
            my_addr_d = ovr_q[tws_pkg::TWS_OVR_ADDR_MSB:tws_pkg::TWS_OVR_ADDR_LSB];
        end else if (ovr_q[tws_pkg::TWS_OVR_PIN_BIT] & saddr_s) begin
            my_addr_d = tws_pkg::TWS_ALT_SLV_ADDR;
        end else begin
            my_addr_d = tws_pkg::TWS_DEF_SLV_ADDR;
        end
        if (wr_tgl_s != wr_seen_q) begin
            // Write from the link
            if (wr_addr_q == tws_pkg::TWS_OVR_HI_ADDR) begin
                ovr_d[15:8] = wr_data_q;
            end else if (wr_addr_q == tws_pkg::TWS_OVR_LO_ADDR) begin
                ovr_d[7:0] = wr_data_q;
            end else if (wr_addr_q[15:1] != tws_pkg::TWS_STAT_HI_ADDR[15:1]) begin
                wr_stb_d    = 1'h1;
                reg_addr_d  = wr_addr_q;
                reg_wdata_d = wr_data_q;
            end
        end else if (fetch_tgl_s != fetch_seen_q) begin
            // Prefetch for the next read byte
            fetch_seen_d = fetch_tgl_s;
            fetch_pend_d = 1'h1;
            reg_addr_d   = ptr_q;
        end
        if (fetch_pend_q) begin
            unique case (reg_addr_q)
                tws_pkg::TWS_OVR_HI_ADDR:  rd_data_d = ovr_q[15:8];
                tws_pkg::TWS_OVR_LO_ADDR:  rd_data_d = ovr_q[7:0];
                tws_pkg::TWS_STAT_HI_ADDR: rd_data_d = tws_pkg::TWS_ZERO_BYTE;
                tws_pkg::TWS_STAT_LO_ADDR: rd_data_d = {my_addr_q, 1'h0};
                default:                   rd_data_d = reg_rdata;
            endcase
        end
    end

    // System registers; synchronous reset acts even while ce is low, otherwise frozen while ce is low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ovr_q        <= tws_pkg::TWS_OVR_RESET;
            my_addr_q    <= tws_pkg::TWS_DEF_SLV_ADDR;
            wr_seen_q    <= 1'h0;
            fetch_seen_q <= 1'h0;
            fetch_pend_q <= 1'h0;
            wr_stb_q     <= 1'h0;
            reg_addr_q   <= 16'h0000;
            reg_wdata_q  <= 8'h00;
            rd_data_q    <= 8'h00;
        end else if (ce) begin
            ovr_q        <= ovr_d;
            my_addr_q    <= my_addr_d;
            wr_seen_q    <= wr_seen_d;
            fetch_seen_q <= fetch_seen_d;
            fetch_pend_q <= fetch_pend_d;
            wr_stb_q     <= wr_stb_d;
            reg_addr_q   <= reg_addr_d;
            reg_wdata_q  <= reg_wdata_d;
            rd_data_q    <= rd_data_d;
        end
    end

    // Sensor register port
    assign reg_wr_stb = wr_stb_q;
    assign reg_rd_stb = fetch_pend_q;
    assign reg_addr   = reg_addr_q;
    assign reg_wdata  = reg_wdata_q;

endmodule

// >>> sim/tws_slave_monitor.sv
`timescale 1ns/1ns
module tws_slave_monitor #(
    parameter int ADDR_W = 16, // Register address width
    parameter int DATA_W = 8   // Register data width
) (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              ce,
    input wire logic              sclk,
    input wire logic              sda_i,
    input wire logic              sda_o,
    input wire logic              sda_oe,
    input wire logic              saddr,
    input wire logic              reg_wr_stb,
    input wire logic              reg_rd_stb,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic [DATA_W-1:0] reg_rdata
);
    logic oe_rise_q; // Drive seen at the last rising serial clock
    // Async clear, since the serial clock may stand still in reset
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            oe_rise_q <= 1'b0;
        end else begin
            oe_rise_q <= sda_oe;
        end
    end
    a_oe_steady_high: assert property (@(negedge sclk) disable iff (!rst_n) sda_oe |-> oe_rise_q)
        else $error("data drive rose while serial clock high");
    a_open_drain: assert property (@(posedge clk) disable iff (!rst_n) sda_o == 1'b0)
        else $error("data line driven high");
    a_wr_pulse: assert property (@(posedge clk) disable iff (!rst_n) reg_wr_stb |=> !reg_wr_stb)
        else $error("write strobe too long");
    a_rd_pulse: assert property (@(posedge clk) disable iff (!rst_n) reg_rd_stb |=> !reg_rd_stb)
        else $error("read strobe too long");
    a_one_access: assert property (@(posedge clk) disable iff (!rst_n) !(reg_wr_stb && reg_rd_stb))
        else $error("read and write in one cycle");
    a_addr_moves: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(reg_addr) |-> (reg_wr_stb || reg_rd_stb)) else $error("address moved without access");
    a_wdata_moves: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(reg_wdata) |-> reg_wr_stb) else $error("write data moved without write");
    a_reset_values: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> (~|reg_addr && ~|reg_wdata && !sda_oe)) else $error("reset values wrong");
endmodule
bind tws_slave tws_slave_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_tws_slave_monitor (
    .clk(clk), .rst_n(rst_n), .ce(ce), .sclk(sclk), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .saddr(saddr), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

// >>> sim/tws_bus_master.sv
`timescale 1ns/1ns
module tws_bus_master (
    output logic      sclk,   // Serial clock, stands high between frames
    output logic      sda_oe, // High while pulling data low
    input  wire logic sda     // Resolved data line
);
    initial begin
        sclk = 1'b1;
        sda_oe = 1'b0;
    end
    // One bit: data set in the low phase, sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        #40 sda_oe = ~b;
        #40 sclk = 1'b1;
        #40 r = sda;
        #40 sclk = 1'b0;
    endtask
    // Idle pulses give the slave time to settle; also used as restart
    task automatic start();
        logic r;
        bit_io(1'b1, r);
        bit_io(1'b1, r);
        #40 sda_oe = 1'b0;
        #40 sclk = 1'b1;
        #40 sda_oe = 1'b1;
        #40 sclk = 1'b0;
    endtask
    task automatic stop();
        #40 sda_oe = 1'b1;
        #40 sclk = 1'b1;
        #40 sda_oe = 1'b0;
        #40;
    endtask
    // n bits MSB first, acknowledge slot only for whole bytes
    task automatic xfer(input logic [7:0] tx, input logic m_ack, input int n,
                        output logic [7:0] rx, output logic ack_lvl);
        logic r;
        rx = 8'hff;
        ack_lvl = 1'b1;
        for (int i = 7; i > 7 - n; i--) begin
            bit_io(tx[i], r);
            rx[i] = r;
        end
        if (n == 8) begin
            bit_io(m_ack, ack_lvl);
        end
    endtask
endmodule

// >>> sim/tws_slave_tb_top.sv
`timescale 1ns/1ns
module tws_slave_tb_top;
    logic        clk;        // System clock
    logic        rst_n;      // Reset, active low
    logic        saddr;      // Address-select pin
    logic        sclk;       // Serial clock from the master model
    logic        m_sda_oe;   // Master pull-down
    logic        sda_o;      // Device drive value
    logic        sda_oe;     // Device pull-down
    wire         sda_i;      // Line with pull-up
    logic        reg_wr_stb; // Core write strobe
    logic        reg_rd_stb; // Core read strobe
    logic [15:0] reg_addr;   // Core address
    logic [7:0]  reg_wdata;  // Core write data
    int          failures;   // Mismatches
    int          checked;    // Comparisons
    logic [23:0] wr_q[$];    // Core writes seen
    // Core register contents, a pure function of address
    function automatic logic [7:0] core_byte(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction
    assign sda_i = ~(sda_oe | m_sda_oe);
    tws_slave u_tws_slave (.clk(clk), .rst_n(rst_n), .ce(1'b1), .sclk(sclk), .sda_i(sda_i), .sda_o(sda_o),
        .sda_oe(sda_oe), .saddr(saddr), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(core_byte(reg_addr)));
    tws_bus_master u_tws_bus_master (.sclk(sclk), .sda_oe(m_sda_oe), .sda(sda_i));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Sampled mid-cycle so registered outputs have settled
    always @(negedge clk) begin
        if (reg_wr_stb === 1'b1) wr_q.push_back({reg_addr, reg_wdata});
    end
    task automatic end_of_test();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [7:0] b, input logic lvl);
        logic [7:0] rx;
        logic       a;
        u_tws_bus_master.xfer(b, 1'b1, 8, rx, a);
        check(a, lvl);
    endtask
    task automatic get(input logic m_ack, input logic [7:0] exp);
        logic [7:0] rx;
        logic       a;
        u_tws_bus_master.xfer(8'hff, m_ack, 8, rx, a);
        check(rx, exp);
    endtask
    task automatic point(input logic [7:0] sa, input logic [15:0] ra);
        u_tws_bus_master.start();
        send(sa, 1'b0);
        send(ra[15:8], 1'b0);
        send(ra[7:0], 1'b0);
    endtask
    task automatic wr_seq(input logic [7:0] sa, input logic [15:0] ra, input logic [7:0] d0, input logic [7:0] d1);
        wr_q.delete();
        point(sa, ra);
        send(d0, 1'b0);
        send(d1, 1'b0);
        u_tws_bus_master.stop();
    endtask
    task automatic rd_seq(input logic [7:0] sa, input logic [15:0] ra, input logic [7:0] e0, input logic [7:0] e1);
        point(sa, ra);
        u_tws_bus_master.start();
        send(sa | 8'h01, 1'b0);
        get(1'b0, e0);
        get(1'b1, e1);
        u_tws_bus_master.stop();
    endtask
    task automatic probe(input logic [7:0] sa, input logic lvl);
        u_tws_bus_master.start();
        send(sa, lvl);
        u_tws_bus_master.stop();
    endtask
    initial begin
        #2000000;
        failures++;
        end_of_test();
    end
    initial begin
        logic [15:0] ra;
        logic [7:0]  d0;
        logic [7:0]  d1;
        logic        a;
        void'($urandom(16));
        #1 rst_n = 1'b0; // After time zero, so the async resets see an edge
        saddr = 1'b0;
        repeat (10) @(negedge clk);
        check({sda_oe, reg_addr, reg_wdata}, 32'h0);
        rst_n = 1'b1;
        rd_seq(8'h20, 16'h31fc, 8'h00, 8'h00);
        for (int i = 0; i < 4; i++) begin
            ra = (i == 0) ? 16'h30ff : 16'($urandom_range(16'h30fe)); // Carry corner first
            d0 = 8'($urandom);
            d1 = 8'($urandom);
            wr_seq(8'h20, ra, d0, d1);
            for (int k = 0; k < 20 && wr_q.size() < 2; k++) @(negedge clk);
            check(wr_q.size(), 2);
            check(wr_q[0], {ra, d0});
            check(wr_q[1], {ra + 16'h0001, d1});
            rd_seq(8'h20, ra, core_byte(ra), core_byte(ra + 16'h0001));
        end
        probe(8'h22, 1'b1);
        probe(8'h30, 1'b1);
        @(negedge clk) saddr = 1'b1;
        probe(8'h30, 1'b1);
        wr_seq(8'h20, 16'h31fc, 8'h02, 8'h00);
        probe(8'h20, 1'b1);
        rd_seq(8'h30, 16'h31fc, 8'h02, 8'h00);
        wr_seq(8'h30, 16'h31fc, 8'h01, 8'h4a);
        probe(8'h30, 1'b1);
        rd_seq(8'h4a, 16'h31fc, 8'h01, 8'h4a);
        u_tws_bus_master.start();
        u_tws_bus_master.xfer(8'h4a, 1'b1, 4, d0, a); // Aborted half byte
        rd_seq(8'h4a, 16'h31fe, 8'h00, 8'h4a);
        @(negedge clk) rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        probe(8'h4a, 1'b1);
        rd_seq(8'h20, 16'h31fc, 8'h00, 8'h00);
        end_of_test();
    end
endmodule
